// >>> slc_hunt.sv
// Purpose: Per-line sync hunt and receiver active state.
// Assumes: One received bit per valid pulse, LSB first.
// Notes:   Only start or resync may enter the hunt.
`default_nettype none

module slc_hunt import slc_pkg::*; (
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   input  wire logic                  i_enable,
   input  wire logic                  i_start,
   input  wire logic                  i_resync,
   input  wire logic                  i_bit,
   input  wire logic                  i_bit_valid,
   input  wire logic [SLC_CHAR_W-1:0] i_sync_char,
   output logic                       o_active
);
   slc_rx_e                 state_ff;
   slc_rx_e                 nxt_state;
   logic [SLC_CHAR_W-1:0]   shift_ff;
   wire  [SLC_CHAR_W-1:0]   nxt_shift = {i_bit, shift_ff[SLC_CHAR_W-1:1]};
   wire                     match = i_bit_valid && (nxt_shift == i_sync_char);

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         SLC_IDLE:   if (i_start) nxt_state = SLC_HUNT;
         SLC_HUNT:   if (match) nxt_state = SLC_ACTIVE;
         SLC_ACTIVE: nxt_state = SLC_ACTIVE;
         default:    nxt_state = SLC_IDLE;
      endcase
      // Resync re-enters the hunt, or stops a disabled line
      if (i_resync) begin
         nxt_state = i_enable ? SLC_HUNT : SLC_IDLE;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state_ff <= SLC_IDLE;
         shift_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         if (i_bit_valid) shift_ff <= nxt_shift;
      end
   end

   assign o_active = state_ff[2];

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   hunt_finds_a: assert property (
      (state_ff == SLC_HUNT) && match && !i_resync |=> o_active)
      else $error("sync match did not set receiver active");
   idle_holds_a: assert property (
      (state_ff == SLC_IDLE) && !i_start && !i_resync |=>
      (state_ff == SLC_IDLE))
      else $error("idle line left idle without start");
endmodule : slc_hunt

`default_nettype wire

// >>> slc_line_src.sv
// Purpose: Serial line source standing in for the far end of a sync line.
// Assumes: One bit per clock while sending, LSB of the character first.
// Notes:   Between bits the data lines toggle so stale values never match.
`default_nettype none

module slc_line_src import slc_pkg::*; (
   input  wire logic                  i_clk,
   input  wire logic                  i_go,
   input  wire logic [SLC_LINE_W-1:0] i_line,
   input  wire logic [SLC_CHAR_W-1:0] i_char,
   output logic [SLC_NLINES-1:0]      o_bit,
   output logic [SLC_NLINES-1:0]      o_valid,
   output logic                       o_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [SLC_CHAR_W-1:0] sh_ff;
   int                    cnt_ff;
   initial begin
      o_bit = '0; o_valid = '0; o_busy = 1'b0; sh_ff = '0; cnt_ff = 0;
   end
   always @(posedge i_clk) begin
      logic [SLC_NLINES-1:0] b;
      logic [SLC_NLINES-1:0] v;
      b = ~o_bit;
      v = '0;
      if (i_go && !o_busy) begin
         sh_ff  <= i_char;
         cnt_ff <= 0;
         o_busy <= 1'b1;
      end else if (o_busy) begin
         b[i_line] = sh_ff[0];
         v[i_line] = 1'b1;
         sh_ff     <= sh_ff >> 1;
         cnt_ff    <= cnt_ff + 1;
         if (cnt_ff == 7) o_busy <= 1'b0;
      end
      o_bit   <= b;
      o_valid <= v;
   end
endmodule : slc_line_src

`default_nettype wire

// >>> slc_mem.sv
// Purpose: Small storage array with registered read data.
// Assumes: Contents clear on initialize.
// Notes:   Read data lags the read address by one clock.
`default_nettype none

module slc_mem #(
   parameter int AW = 8,
   parameter int DW = 2
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   slc_mem_if.mem   port
);
   logic [DW-1:0] mem_ff [2**AW];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int k = 0; k < 2**AW; k++) begin
            mem_ff[k] <= '0;
         end
         rdata_ff <= '0;
      end else begin
         if (port.we) begin
            mem_ff[port.waddr] <= port.wdata;
         end
         rdata_ff <= mem_ff[port.raddr];
      end
   end

   assign port.rdata = rdata_ff;
endmodule : slc_mem

`default_nettype wire

// >>> slc_mem_if.sv
// Purpose: Write/read port bundle for the small storage arrays.
// Assumes: One write port, one registered read port.
// Notes:   Controller drives addresses, memory returns read data.
`default_nettype none

interface slc_mem_if #(parameter int AW = 8, parameter int DW = 2);
   logic          we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;
   modport ctl (output we, waddr, wdata, raddr, input rdata);
   modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : slc_mem_if

`default_nettype wire

// >>> slc_pkg.sv
// Purpose: Constants for the sync line control register bank.
// Assumes: Classic Wishbone slave, 32-bit data, one aligned word per reg.
// Notes:   Sixteen lines, four groups of four lines.
`default_nettype none

package slc_pkg;
   localparam int          SLC_NLINES    = 16;
   localparam int          SLC_LINE_W    = 4;
   localparam int          SLC_NGRP      = 4;
   localparam int          SLC_REGSEL_W  = 4;
   localparam int          SLC_CODE_W    = 2;
   localparam int          SLC_NIB_W     = 4;
   localparam int          SLC_EXT_W     = 2;
   localparam int          SLC_GRP_W     = 5;
   localparam int          SLC_CHAR_W    = 8;
   localparam int          SLC_ADR_W     = 8;
   // Register byte addresses
   localparam logic [7:0]  SLC_ADR_LCR   = 8'h00;
   localparam logic [7:0]  SLC_ADR_SRS   = 8'h04;
   localparam logic [7:0]  SLC_ADR_EXT   = 8'h08;
   localparam logic [7:0]  SLC_ADR_LSTAT = 8'h0c;
   localparam logic [7:0]  SLC_ADR_SYNC  = 8'h10;
   localparam logic [7:0]  SLC_ADR_ASYNC = 8'h14;
   // Line control field positions
   localparam int          LCR_EXT_LO    = 4;
   localparam int          LCR_CODE_LO   = 9;
   localparam int          LCR_SYNC_SEL  = 10;
   localparam int          LCR_NIB_LO    = 11;
   localparam int          LCR_RX_EN     = 13;
   localparam int          LCR_GRP_HI    = 14;
   localparam int          LCR_STROBE    = 15;
   localparam logic [15:0] LCR_STORE_MSK = 16'h7e00;
   // Secondary register select fields
   localparam int          SRS_LINE_LO   = 0;
   localparam int          SRS_GRP_LO    = 2;
   localparam int          SRS_REG_LO    = 8;
   localparam logic [15:0] SRS_MSK       = 16'h0f0f;
   // Line state bits
   localparam int          LST_ACTIVE    = 0;
   localparam int          LST_RESYNC    = 1;
   localparam logic [15:0] SYNC_RST      = 16'h0000;

   typedef enum logic [2:0] {
      SLC_IDLE   = 3'b001,
      SLC_HUNT   = 3'b010,
      SLC_ACTIVE = 3'b100
   } slc_rx_e;
endpackage : slc_pkg

`default_nettype wire

// >>> slc_top.sv
// Purpose: Line control register bank with Wishbone register access.
// Assumes: Classic Wishbone, one wait state, initialize is i_resetn.
// Notes:   Async or sync handling is chosen per line by i_line_async.
//
// The address map and the Wishbone interface to the registers were decided locally.
`default_nettype none

module slc_top import slc_pkg::*; (
   input  wire logic                    i_clk,
   input  wire logic                    i_resetn,
   input  wire logic                    i_wb_cyc,
   input  wire logic                    i_wb_stb,
   input  wire logic                    i_wb_we,
   input  wire logic [SLC_ADR_W-1:0]    i_wb_adr,
   input  wire logic [3:0]              i_wb_sel,
   input  wire logic [31:0]             i_wb_dat,
   output logic                         o_wb_ack,
   output logic [31:0]                  o_wb_dat,
   input  wire logic [SLC_NLINES-1:0]   i_line_async,
   input  wire logic [SLC_NLINES-1:0]   i_rx_bit,
   input  wire logic [SLC_NLINES-1:0]   i_rx_valid,
   output logic [SLC_NLINES-1:0]        o_sync_sel,
   output logic [SLC_NLINES-1:0]        o_rx_enable,
   output logic [SLC_NLINES-1:0]        o_rx_active,
   output logic [SLC_NGRP*SLC_GRP_W-1:0] o_group_ctl
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                              input logic [15:0] nw,
                                              input logic [1:0]  sel);
      lane_merge = {sel[1] ? nw[15:8] : old[15:8],
                    sel[0] ? nw[7:0]  : old[7:0]};
   endfunction : lane_merge

   function automatic logic [SLC_GRP_W-1:0] grp_bits(
      input logic [15:0] v);
      grp_bits = {v[LCR_GRP_HI], v[LCR_NIB_LO+1:LCR_CODE_LO]};
   endfunction : grp_bits

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic                   ack_ff;
   logic [31:0]            dat_ff;
   logic [15:0]            lcr_ff;
   logic [15:0]            srs_ff;
   logic [15:0]            sync_ch_ff;
   logic [SLC_NLINES-1:0]  sync_sel_ff;
   logic [SLC_NLINES-1:0]  rx_en_ff;
   logic [SLC_GRP_W-1:0]   grp_ff [SLC_NGRP];
   logic [SLC_NLINES-1:0]  active_w;

   slc_mem_if #(.AW(SLC_LINE_W + SLC_REGSEL_W), .DW(SLC_EXT_W)) ext_if ();
   slc_mem_if #(.AW(SLC_LINE_W + SLC_CODE_W),   .DW(SLC_NIB_W)) asy_if ();

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   wire req       = i_wb_cyc & i_wb_stb;
   wire rd_go     = req & ~ack_ff;
   wire wr_go     = req & i_wb_we & ack_ff;
   wire adr_lcr   = (i_wb_adr == SLC_ADR_LCR);
   wire adr_srs   = (i_wb_adr == SLC_ADR_SRS);
   wire adr_ext   = (i_wb_adr == SLC_ADR_EXT);
   wire adr_lstat = (i_wb_adr == SLC_ADR_LSTAT);
   wire adr_sync  = (i_wb_adr == SLC_ADR_SYNC);
   wire adr_async = (i_wb_adr == SLC_ADR_ASYNC);

   wire [SLC_LINE_W-1:0]   line   = srs_ff[SRS_LINE_LO +: SLC_LINE_W];
   wire [1:0]              grp    = srs_ff[SRS_GRP_LO +: 2];
   wire [SLC_REGSEL_W-1:0] regsel = srs_ff[SRS_REG_LO +: SLC_REGSEL_W];
   wire                    is_async = i_line_async[line];

   // Data written with the strobe is what gets committed
   wire [15:0] lcr_wr_val = lane_merge(lcr_ff, i_wb_dat[15:0],
                                       i_wb_sel[1:0]);
   wire [15:0] srs_wr_val = lane_merge(srs_ff, i_wb_dat[15:0],
                                       i_wb_sel[1:0]);
   wire [15:0] syn_wr_val = lane_merge(sync_ch_ff, i_wb_dat[15:0],
                                       i_wb_sel[1:0]);
   wire strobe      = wr_go & adr_lcr & i_wb_sel[1]
                      & i_wb_dat[LCR_STROBE];
   wire sync_commit = strobe & ~is_async;
   wire async_commit = strobe & is_async;
   wire resync_req  = wr_go & adr_lstat & i_wb_sel[0]
                      & i_wb_dat[LST_RESYNC];

   wire [SLC_NLINES-1:0] line_hot = SLC_NLINES'(1) << line;
   // Only a 0->1 enable change starts a hunt
   wire [SLC_NLINES-1:0] rx_start =
      (sync_commit & lcr_wr_val[LCR_RX_EN] & ~rx_en_ff[line])
      ? line_hot : '0;
   wire [SLC_NLINES-1:0] rx_resync = resync_req ? line_hot : '0;

   // ------------------------------------------------------------
   // Storage arrays
   // ------------------------------------------------------------
   assign ext_if.we    = wr_go & adr_ext & i_wb_sel[0];
   assign ext_if.waddr = {line, regsel};
   assign ext_if.wdata = i_wb_dat[SLC_EXT_W-1:0];
   assign ext_if.raddr = {line, regsel};

   assign asy_if.we    = async_commit;
   assign asy_if.waddr = {line, lcr_wr_val[LCR_CODE_LO +: SLC_CODE_W]};
   assign asy_if.wdata = lcr_wr_val[LCR_NIB_LO +: SLC_NIB_W];
   assign asy_if.raddr = {line, lcr_ff[LCR_CODE_LO +: SLC_CODE_W]};

   slc_mem #(.AW(SLC_LINE_W + SLC_REGSEL_W), .DW(SLC_EXT_W)) u_ext (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .port     (ext_if.mem)
   );

   slc_mem #(.AW(SLC_LINE_W + SLC_CODE_W), .DW(SLC_NIB_W)) u_async (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .port     (asy_if.mem)
   );

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   wire [15:0] rd_lcr   = 16'(ext_if.rdata) << LCR_EXT_LO;
   wire [15:0] rd_lstat = 16'(active_w[line]) << LST_ACTIVE;
   wire [15:0] rd_mux   =
      adr_lcr   ? rd_lcr :
      adr_srs   ? srs_ff :
      adr_ext   ? 16'(ext_if.rdata) :
      adr_lstat ? rd_lstat :
      adr_sync  ? sync_ch_ff :
      adr_async ? 16'(asy_if.rdata) : 16'h0000;

   // ------------------------------------------------------------
   // Bus registers
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= rd_go;
         dat_ff <= rd_go ? {16'h0000, rd_mux} : 32'h0000_0000;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         lcr_ff     <= 16'h0000;
         srs_ff     <= 16'h0000;
         sync_ch_ff <= SYNC_RST;
      end else begin
         // Strobe is never stored, so it reads back clear
         if (wr_go && adr_lcr) lcr_ff <= lcr_wr_val & LCR_STORE_MSK;
         if (wr_go && adr_srs) srs_ff <= srs_wr_val & SRS_MSK;
         if (wr_go && adr_sync) sync_ch_ff <= syn_wr_val;
      end
   end

   // ------------------------------------------------------------
   // Line and group control storage
   // ------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sync_sel_ff <= '0;
         rx_en_ff    <= '0;
      end else if (sync_commit) begin
         sync_sel_ff[line] <= lcr_wr_val[LCR_SYNC_SEL];
         rx_en_ff[line]    <= lcr_wr_val[LCR_RX_EN];
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int g = 0; g < SLC_NGRP; g++) grp_ff[g] <= '0;
      end else if (sync_commit) begin
         grp_ff[grp] <= grp_bits(lcr_wr_val);
      end
   end

   // ------------------------------------------------------------
   // Per-line sync hunters
   // ------------------------------------------------------------
   for (genvar n = 0; n < SLC_NLINES; n++) begin : g_line
      slc_hunt u_hunt (
         .i_clk       (i_clk),
         .i_resetn    (i_resetn),
         .i_enable    (rx_en_ff[n]),
         .i_start     (rx_start[n]),
         .i_resync    (rx_resync[n]),
         .i_bit       (i_rx_bit[n]),
         .i_bit_valid (i_rx_valid[n] & rx_en_ff[n]),
         .i_sync_char (sync_sel_ff[n] ? sync_ch_ff[15:8]
                                      : sync_ch_ff[7:0]),
         .o_active    (active_w[n])
      );
   end

   for (genvar g = 0; g < SLC_NGRP; g++) begin : g_grp
      assign o_group_ctl[g*SLC_GRP_W +: SLC_GRP_W] = grp_ff[g];
   end

   assign o_wb_ack    = ack_ff;
   assign o_wb_dat    = dat_ff;
   assign o_sync_sel  = sync_sel_ff;
   assign o_rx_enable = rx_en_ff;
   assign o_rx_active = active_w;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic [SLC_LINE_W-1:0] chk_line_ff;
   logic [15:0]           chk_val_ff;
   logic [SLC_NLINES-1:0] chk_start_ff;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         chk_line_ff  <= '0;
         chk_val_ff   <= 16'h0000;
         chk_start_ff <= '0;
      end else begin
         chk_line_ff  <= line;
         chk_val_ff   <= lcr_wr_val;
         chk_start_ff <= rx_start;
      end
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_sync_strobe;
      sync_commit;
   endsequence

   sequence s_lcr_read;
      rd_go && adr_lcr;
   endsequence

   sync_sel_store_a: assert property (
      s_sync_strobe |=> o_sync_sel[chk_line_ff] == chk_val_ff[LCR_SYNC_SEL])
      else $error("sync select not stored for selected line");
   rx_en_store_a: assert property (
      s_sync_strobe |=> o_rx_enable[chk_line_ff] == chk_val_ff[LCR_RX_EN])
      else $error("receiver enable not stored for selected line");
   group_store_a: assert property (
      s_sync_strobe |=> o_group_ctl[chk_line_ff[3:2]*SLC_GRP_W +: SLC_GRP_W]
                        == grp_bits(chk_val_ff))
      else $error("group control not stored for selected group");
   strobe_clear_a: assert property (
      wr_go && adr_lcr |=> lcr_ff[LCR_STROBE] == 1'b0)
      else $error("strobe bit did not clear itself");
   ext_read_a: assert property (
      s_lcr_read |=> o_wb_ack &&
                     o_wb_dat[LCR_EXT_LO +: SLC_EXT_W] == ext_if.rdata)
      else $error("extended address bits not returned");
   lcr_zero_read_a: assert property (
      s_lcr_read |=> o_wb_dat[31:LCR_EXT_LO+SLC_EXT_W] == '0 &&
                     o_wb_dat[LCR_EXT_LO-1:0] == '0)
      else $error("write-only line control bits read nonzero");
   no_restart_a: assert property (
      sync_commit && rx_en_ff[line] |-> rx_start == '0)
      else $error("rewritten enable restarted the hunt");
   start_hunt_a: assert property (
      chk_start_ff != '0 |-> (o_rx_active & chk_start_ff) == '0)
      else $error("started line did not enter the hunt");
   async_route_a: assert property (
      async_commit |=> $stable(o_rx_enable) && $stable(o_sync_sel))
      else $error("async strobe altered sync line storage");
   ack_single_a: assert property (
      o_wb_ack |=> !o_wb_ack)
      else $error("ack held for more than one cycle");
endmodule : slc_top

`default_nettype wire

// >>> tb_top.sv
// Purpose: Self-checking bench for the line control register bank.
// Assumes: Wishbone answers in its own time; waits are bounded.
// Notes:   Reference model tracks per-line and per-group storage.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import slc_pkg::*;
   logic i_clk = 0, i_resetn = 0, cyc = 0, stb = 0, we = 0, go = 0;
   logic [7:0]  adr = '0;
   logic [3:0]  sel = '0;
   logic [31:0] dat = '0, q;
   logic        ack;
   logic [31:0] rdat;
   logic [15:0] l_async = '0, rbit, rval, ss, en, act;
   logic [19:0] grp;
   logic [15:0] e_ss, e_en, e_act;
   logic [19:0] e_grp;
   logic [3:0]  s_line = '0, nib;
   logic [7:0]  s_char = '0, ca, cb;
   logic        busy;
   int n_mismatch = 0, cmp_count = 0, seed = 32'h12df;
   always #2 i_clk = ~i_clk;
   slc_top u_slc_top (.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(dat), .o_wb_ack(ack), .o_wb_dat(rdat),
      .i_line_async(l_async), .i_rx_bit(rbit), .i_rx_valid(rval),
      .o_sync_sel(ss), .o_rx_enable(en), .o_rx_active(act),
      .o_group_ctl(grp));
   slc_line_src u_slc_line_src (.i_clk(i_clk), .i_go(go), .i_line(s_line),
      .i_char(s_char), .o_bit(rbit), .o_valid(rval), .o_busy(busy));
   //--------------------------------------------------------------
   // Tasks
   //--------------------------------------------------------------
   task automatic conclude();
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : conclude
   task automatic bad(input string m);
      n_mismatch++;
      $display("ERROR %0t %s", $time, m);
   endtask : bad
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      int n;
      @(posedge i_clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= {16'h0, d}; sel <= 4'h3;
      n = 0;
      do begin @(posedge i_clk); n++; end while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 0; stb <= 0;
      if (n >= 50) bad("no bus answer");
   endtask : wb
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      wb(1'b0, a, 16'h0);
      cmp_count++;
      if (q !== {16'h0, e}) bad("read data differs");
   endtask : chk_rd
   task automatic chk_out();
      repeat (2) @(posedge i_clk);
      cmp_count++;
      if (ss !== e_ss || en !== e_en || act !== e_act || grp !== e_grp)
         bad("line outputs differ");
   endtask : chk_out
   // Select a line and write the line control word, updating the model
   task automatic line_control(input logic [3:0] ln, input logic [15:0] d);
      wb(1'b1, SLC_ADR_SRS, {12'h0, ln});
      wb(1'b1, SLC_ADR_LCR, d);
      if (d[15] && !l_async[ln]) begin
         if (d[13] && !e_en[ln]) e_act[ln] = 1'b0;
         e_en[ln] = d[13];
         e_ss[ln] = d[10];
         e_grp[5*ln[3:2] +: 5] = {d[14], d[12:9]};
      end
   endtask : line_control
   task automatic send(input logic [3:0] ln, input logic [7:0] c);
      int n;
      @(posedge i_clk);
      s_line <= ln; s_char <= c; go <= 1;
      @(posedge i_clk);
      go <= 0;
      n = 0;
      do begin @(posedge i_clk); n++; end while (busy !== 1'b0 && n < 50);
   endtask : send
   task automatic init();
      e_ss = '0; e_en = '0; e_act = '0; e_grp = '0;
      i_resetn <= 0;
      repeat (2) @(posedge i_clk);
      i_resetn <= 1;
   endtask : init
   //--------------------------------------------------------------
   // Tests
   //--------------------------------------------------------------
   initial begin
      #100000;
      bad("watchdog");
      conclude();
   end
   initial begin
      init();
      chk_out();
      chk_rd(SLC_ADR_LCR, 16'h0);
      ca = $random(seed);
      cb = $random(seed);
      wb(1'b1, SLC_ADR_SYNC, {cb, ca});
      chk_rd(SLC_ADR_SYNC, {cb, ca});
      send(4'd5, cb);
      chk_out();
      line_control(4'd5, 16'hfe00);
      chk_out();
      line_control(4'd5, 16'h7e00);
      chk_out();
      line_control(4'd9, 16'ha000);
      chk_out();
      $display("test store done");
      line_control(4'd5, 16'ha400);
      wb(1'b1, SLC_ADR_EXT, 16'h0002);
      chk_rd(SLC_ADR_EXT, 16'h0002);
      chk_rd(SLC_ADR_SRS, 16'h0005);
      chk_rd(SLC_ADR_LCR, 16'h0020);
      send(4'd5, cb);
      e_act[5] = 1'b1;
      chk_out();
      chk_rd(SLC_ADR_LSTAT, 16'h0001);
      line_control(4'd5, 16'ha400);
      chk_out();
      wb(1'b1, SLC_ADR_LSTAT, 16'h0002);
      e_act[5] = 1'b0;
      chk_out();
      send(4'd5, cb);
      e_act[5] = 1'b1;
      chk_out();
      line_control(4'd5, 16'h8400);
      chk_out();
      wb(1'b1, SLC_ADR_LSTAT, 16'h0002);
      e_act[5] = 1'b0;
      send(4'd5, cb);
      chk_out();
      line_control(4'd9, 16'ha000);
      send(4'd9, ca);
      e_act[9] = 1'b1;
      chk_out();
      $display("test hunt done");
      l_async[7] <= 1'b1;
      for (int c = 0; c < 4; c++) begin
         nib = $random(seed);
         line_control(4'd7, {1'b1, nib, 2'(c), 9'h0});
         chk_rd(SLC_ADR_ASYNC, {12'h0, nib});
      end
      chk_out();
      chk_rd(8'hfc, 16'h0);
      $display("test async done");
      init();
      chk_out();
      chk_rd(SLC_ADR_LCR, 16'h0);
      $display("test reset done");
      conclude();
   end
endmodule : tb_top

`default_nettype wire
